// File: verilog/serial_status.sv
// Status flags of the serial port with register port and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "status_params.svh"
module serial_status (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [`ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic cts_n_in,
	input wire logic tx_load_in,
	input wire logic tx_last_bit_in,
	input wire logic rx_done_in,
	input wire logic [`DATA_W-1:0] rx_char_in,
	input wire logic rx_stop_bit_in,
	input wire logic rx_parity_bad_in,
	input wire logic rx_noise_in,
	input wire logic rx_idle_in,
	output logic [`DATA_W-1:0] tx_char_out,
	output logic tx_pending_out,
	output logic rx_halted_out,
	output logic rx_full_req_out,
	output logic tx_path_on_out,
	output logic irq_out
);
	import status_pkg::*;

	// ==========================================
	// Register decode
	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	logic wr_status;
	logic wr_data;
	logic wr_ctrl;
	logic wr_clr;
	logic wr_en;
	logic rd_status;
	logic rd_data;
	assign wr_status = wr_in && hit(addr_in, `OFS_STATUS);
	assign wr_data = wr_in && hit(addr_in, `OFS_DATA);
	assign wr_ctrl = wr_in && hit(addr_in, `OFS_CTRL);
	assign wr_clr = wr_in && hit(addr_in, `OFS_IRQ_STAT);
	assign wr_en = wr_in && hit(addr_in, `OFS_IRQ_EN);
	assign rd_status = rd_in && hit(addr_in, `OFS_STATUS);
	assign rd_data = rd_in && hit(addr_in, `OFS_DATA);

	// ==========================================
	// Control register
	logic [2:0] ctrl_q;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ctrl_q <= `CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= wdata_in[2:0];
		end
	end
	logic tx_on;
	logic cts_en;
	logic async_mode;
	assign tx_on = ctrl_q[`BIT_CTL_TXON];
	assign cts_en = ctrl_q[`BIT_CTL_CTSE];
	assign async_mode = ctrl_q[`BIT_CTL_ASYNC];
	assign tx_path_on_out = tx_on;

	// ==========================================
	// Clear-to-send input
	logic cts_level;
	logic cts_change;
	pin_sync cts_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.pin_in(cts_n_in),
		.level_out(cts_level),
		.change_out(cts_change)
	);

	// ==========================================
	// Transmit holding register
	data_char_t tx_char_q;
	logic txe_q;
	logic tc_q;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tx_char_q <= 9'h000;
		end else if (wr_data) begin
			tx_char_q <= wdata_in[`DATA_W-1:0];
		end
	end
	assign tx_char_out = tx_char_q;
	assign tx_pending_out = !txe_q;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			txe_q <= 1'h1;
		end else if (wr_data) begin
			txe_q <= 1'h0;
		end else if (tx_load_in) begin
			txe_q <= 1'h1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tc_q <= 1'h1;
		// off or frame end with nothing pending
		end else if (!tx_on || (tx_last_bit_in && txe_q && !wr_data)) begin
			tc_q <= 1'h1;
		end else if (wr_data) begin
			tc_q <= 1'h0;
		end
	end

	// ==========================================
	// Receive side
	data_char_t rx_char_q;
	logic rxf_q;
	logic halted_q;
	logic [4:0] err_q;
	logic fe_ev;
	logic pe_ev;
	logic rx_take;
	assign rx_take = rx_done_in && !halted_q;
	// low stop bit in asynchronous mode
	assign fe_ev = rx_take && async_mode && !rx_stop_bit_in;
	assign pe_ev = rx_take && rx_parity_bad_in;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rx_char_q <= 9'h000;
		end else if (rx_take) begin
			rx_char_q <= rx_char_in;
		end
	end

	// reception stops until the errors are cleared
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			halted_q <= 1'h0;
		end else if (fe_ev || pe_ev) begin
			halted_q <= 1'h1;
		end else if (!err_q[`BIT_FE] && !err_q[`BIT_PE]) begin
			halted_q <= 1'h0;
		end
	end
	assign rx_halted_out = halted_q;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rxf_q <= 1'h0;
		end else if (rx_take) begin
			rxf_q <= 1'h1;
		end else if (rd_data || (wr_status && !wdata_in[`BIT_RXF])) begin
			rxf_q <= 1'h0;
		end
	end

	// no receive-full request for a bad frame
	logic rx_req_q;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rx_req_q <= 1'h0;
		end else if (rx_take) begin
			rx_req_q <= !(fe_ev || pe_ev);
		end else if (rd_data || (wr_status && !wdata_in[`BIT_RXF])) begin
			rx_req_q <= 1'h0;
		end
	end
	assign rx_full_req_out = rx_req_q;

	// ==========================================
	// Error, idle and clear-to-send flags
	logic [4:0] err_ev;
	logic [4:0] snap_q;
	logic armed_q;
	always_comb begin
		err_ev = 5'h00;
		err_ev[`BIT_PE] = pe_ev;
		err_ev[`BIT_FE] = fe_ev;
		err_ev[`BIT_NF] = rx_take && rx_noise_in;
		// accepted frame ends with unread data; a halted receiver takes no frame
		err_ev[`BIT_ORE] = rx_take && rxf_q;
		err_ev[`BIT_IDLE] = rx_idle_in;
	end

	// remember which flags the status read saw
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			snap_q <= 5'h00;
			armed_q <= 1'h0;
		end else if (rd_status) begin
			snap_q <= err_q;
			armed_q <= 1'h1;
		end else if (rd_data) begin
			armed_q <= 1'h0;
		end
	end

	// status then data read, a new event wins
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			err_q <= 5'h00;
		end else if (rd_data && armed_q) begin
			err_q <= (err_q & ~snap_q) | err_ev;
		end else begin
			err_q <= err_q | err_ev;
		end
	end

	logic cts_q;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cts_q <= 1'h0;
		// change counted only with flow control on
		end else if (cts_en && cts_change) begin
			cts_q <= 1'h1;
		end else if (wr_status && !wdata_in[`BIT_CTS]) begin
			cts_q <= 1'h0;
		end
	end

	// ==========================================
	// Status word, interrupt and read data
	status_word_t status;
	always_comb begin
		status = 10'h000;
		status[4:0] = err_q;
		status[`BIT_RXF] = rxf_q;
		status[`BIT_TC] = tc_q;
		status[`BIT_TXE] = txe_q;
		status[`BIT_CTS] = cts_q;
	end

	// Sticky event bits: rx ready, errors and idle, cts, tc rise, tx load
	status_word_t ev;
	status_word_t ist_q;
	status_word_t ien_q;
	logic tc_prev_q;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tc_prev_q <= 1'h1;
		end else begin
			tc_prev_q <= tc_q;
		end
	end
	always_comb begin
		ev = 10'h000;
		ev[4:0] = err_ev;
		ev[`BIT_RXF] = rx_take && !(fe_ev || pe_ev);
		ev[`BIT_TC] = tc_q && !tc_prev_q;
		ev[`BIT_TXE] = tx_load_in;
		ev[`BIT_CTS] = cts_en && cts_change;
	end
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ist_q <= 10'h000;
		end else if (wr_en) begin
			ist_q <= ist_q | ev;
		end else begin
			ist_q <= (ist_q & ~(wr_clr ? wdata_in[`IRQ_W-1:0] : 10'h000)) | ev;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ien_q <= 10'h000;
		end else if (wr_en) begin
			ien_q <= wdata_in[`IRQ_W-1:0];
		end
	end
	assign irq_out = |(ist_q & ien_q);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_status) begin
			rdata_out <= {22'h000000, status};
		end else if (rd_data) begin
			rdata_out <= {23'h000000, rx_char_q};
		end else if (rd_in && hit(addr_in, `OFS_CTRL)) begin
			rdata_out <= {29'h00000000, ctrl_q};
		end else if (rd_in && hit(addr_in, `OFS_IRQ_STAT)) begin
			rdata_out <= {22'h000000, ist_q};
		end else if (rd_in && hit(addr_in, `OFS_IRQ_EN)) begin
			rdata_out <= {22'h000000, ien_q};
		end else begin
			rdata_out <= 32'h0000_0000;
		end
	end

	// ==========================================
	// Checks
	txe_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		wr_data |=> !txe_q) else $error("holding empty not cleared by write");
	txe_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		tx_load_in && !wr_data |=> txe_q) else $error("holding empty not set on load");
	tc_off_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		!tx_on |=> tc_q) else $error("complete not set with transmitter off");
	rxf_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		rx_take |=> rxf_q) else $error("receive full not set");
	rxf_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_data && !rx_take |=> !rxf_q) else $error("receive full not cleared by read");
	ovr_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		rx_take && rxf_q |=> err_q[`BIT_ORE]) else $error("overrun missed");
	bad_frame_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		fe_ev || pe_ev |=> halted_q && !rx_req_q) else $error("bad frame not halted");
	cts_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		!cts_en && !cts_q |=> !cts_q) else $error("cts flag set while disabled");
	// Status read followed within a few cycles by the data read
	sequence status_then_data;
		rd_status ##[1:4] rd_data;
	endsequence
	seq_keep_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		status_then_data |=> ((err_q & ~snap_q) == ($past(err_q) & ~snap_q))
			|| ($past(err_ev) != 5'h00)) else $error("read sequence cleared a new flag");
	seq_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_data && armed_q |=> (err_q & snap_q) == ($past(err_ev) & snap_q))
		else $error("read sequence left a seen flag set");
endmodule
`default_nettype wire

// File: verilog/status_params.svh
// Register offsets, bit positions, reset values and timing constants of the serial status block
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

`define ADDR_W 6
`define OFS_STATUS 6'h00
`define OFS_DATA 6'h04
`define OFS_CTRL 6'h08
`define OFS_IRQ_STAT 6'h0C
`define OFS_IRQ_EN 6'h10
`define BIT_PE 0
`define BIT_FE 1
`define BIT_NF 2
`define BIT_ORE 3
`define BIT_IDLE 4
`define BIT_RXF 5
`define BIT_TC 6
`define BIT_TXE 7
`define BIT_CTS 9
`define BIT_CTL_TXON 0
`define BIT_CTL_CTSE 1
`define BIT_CTL_ASYNC 2
`define SEQ_MASK 10'h01F
`define STATUS_RESET 10'h0C0
`define CTRL_RESET 3'h4
`define IRQ_W 10
`define DATA_W 9
`define TC_NS 20
`define MCLK_MHZ 50

`endif

// File: verilog/status_pkg.sv
// Types shared by the serial status block
`include "status_params.svh"
package status_pkg;
	typedef logic [`IRQ_W-1:0] status_word_t;
	typedef logic [`DATA_W-1:0] data_char_t;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage

// File: verilog/pin_sync.sv
// Three-stage synchroniser with agreement-based change detection
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic pin_in,
	output logic level_out,
	output logic change_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s1_q <= 1'h1;
			s2_q <= 1'h1;
			s3_q <= 1'h1;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A new level counts only once stages two and three agree
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			lvl_q <= 1'h1;
		end else if (s2_q == s3_q) begin
			lvl_q <= s3_q;
		end
	end

	assign level_out = lvl_q;
	assign change_out = (s2_q == s3_q) && (s3_q != lvl_q);
endmodule
`default_nettype wire

// File: verification/far_end_model.sv
// Behavioural model of the remote transceiver feeding the receive side
`timescale 1ns/10ps
`default_nettype none
`include "status_params.svh"
module far_end_model (
	input wire logic mclk_in,
	output logic cts_n_out,
	output logic rx_done_out,
	output logic [`DATA_W-1:0] rx_char_out,
	output logic rx_stop_bit_out,
	output logic rx_parity_bad_out,
	output logic rx_noise_out,
	output logic rx_idle_out
);
	import status_pkg::*;
	initial begin
		cts_n_out = 1'b1;
		rx_done_out = 1'b0;
		rx_char_out = 9'h000;
		rx_stop_bit_out = 1'b1;
		rx_parity_bad_out = 1'b0;
		rx_noise_out = 1'b0;
		rx_idle_out = 1'b0;
	end
	// ==========================================
	// Frame delivery
	// Qualifiers are inverted after the strobe so stale values cannot pass for valid ones
	task send(input data_char_t c, input logic stop, input logic par, input logic nz);
		@(posedge mclk_in);
		rx_char_out <= c;
		rx_stop_bit_out <= stop;
		rx_parity_bad_out <= par;
		rx_noise_out <= nz;
		rx_done_out <= 1'b1;
		@(posedge mclk_in);
		rx_done_out <= 1'b0;
		rx_char_out <= ~c;
		rx_stop_bit_out <= ~stop;
		rx_parity_bad_out <= ~par;
		rx_noise_out <= ~nz;
	endtask
	task idle_frame;
		@(posedge mclk_in);
		rx_idle_out <= 1'b1;
		@(posedge mclk_in);
		rx_idle_out <= 1'b0;
	endtask
	task toggle_cts;
		@(posedge mclk_in);
		cts_n_out <= ~cts_n_out;
	endtask
endmodule
`default_nettype wire

// File: verification/tb_serial_status_flags.sv
// Self-checking bench of the serial status flags
`timescale 1ns/10ps
`default_nettype none
`include "status_params.svh"
module tb_serial_status_flags;
	import status_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [5:0] addr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic tx_load = 1'b0;
	logic tx_last = 1'b0;
	logic [31:0] rdata;
	logic cts_n, rx_done, rx_stop, rx_par, rx_nz, rx_idle;
	logic [`DATA_W-1:0] rx_char, tx_char;
	logic tx_pend, rx_halt, rx_req, tx_on, irq;
	int fails = 0;
	int n_tests = 0;
	always #10 mclk_in = ~mclk_in;
	far_end_model u_far (.mclk_in(mclk_in), .cts_n_out(cts_n), .rx_done_out(rx_done), .rx_char_out(rx_char),
		.rx_stop_bit_out(rx_stop), .rx_parity_bad_out(rx_par), .rx_noise_out(rx_nz), .rx_idle_out(rx_idle));
	serial_status u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
		.rd_in(rd_s), .rdata_out(rdata), .cts_n_in(cts_n), .tx_load_in(tx_load), .tx_last_bit_in(tx_last),
		.rx_done_in(rx_done), .rx_char_in(rx_char), .rx_stop_bit_in(rx_stop), .rx_parity_bad_in(rx_par),
		.rx_noise_in(rx_nz), .rx_idle_in(rx_idle), .tx_char_out(tx_char), .tx_pending_out(tx_pend),
		.rx_halted_out(rx_halt), .rx_full_req_out(rx_req), .tx_path_on_out(tx_on), .irq_out(irq));
	// ==========================================
	// Bus and compare helpers
	task report_and_stop;
		if (fails == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		n_tests++;
		if ((got & msk) !== exp) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got & msk, exp);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk_in);
		wr_s <= 1'b0;
	endtask
	task rchk(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] msk);
		@(posedge mclk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk_in);
		rd_s <= 1'b0;
		#1;
		chk(rdata, exp, msk);
	endtask
	task pulse(input logic last);
		@(posedge mclk_in);
		if (last) begin
			tx_last <= 1'b1;
		end else begin
			tx_load <= 1'b1;
		end
		@(posedge mclk_in);
		tx_load <= 1'b0;
		tx_last <= 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task t_reset_cts;
		rchk(6'h00, 32'h0C0, 32'hFFFFFFFF);
		rchk(6'h20, 32'h0, 32'hFFFFFFFF);
		u_far.toggle_cts();
		repeat (8) @(posedge mclk_in);
		rchk(6'h00, 32'h0C0, 32'hFFFFFFFF);
		wr(6'h08, 32'h6);
		u_far.toggle_cts();
		repeat (8) @(posedge mclk_in);
		rchk(6'h00, 32'h2C0, 32'hFFFFFFFF);
		wr(6'h00, 32'hFFFFFC00);
		rchk(6'h00, 32'h0C0, 32'hFFFFFFFF);
	endtask
	task t_tx;
		wr(6'h08, 32'h5);
		wr(6'h10, 32'h80);
		chk({31'h0, tx_on}, 32'h1, 32'h1);
		wr(6'h04, 32'h1A5);
		rchk(6'h00, 32'h000, 32'h3FF);
		chk({22'h0, tx_pend, tx_char}, 32'h3A5, 32'h3FF);
		pulse(1'b0);
		rchk(6'h00, 32'h080, 32'h3FF);
		chk({31'h0, irq}, 32'h1, 32'h1);
		wr(6'h0C, 32'h3FF);
		rchk(6'h0C, 32'h0, 32'h80);
		chk({31'h0, irq}, 32'h0, 32'h1);
		wr(6'h10, 32'h0);
		pulse(1'b1);
		rchk(6'h00, 32'h0C0, 32'h3FF);
		chk({31'h0, irq}, 32'h0, 32'h1);
		wr(6'h04, 32'h0F0);
		wr(6'h00, 32'h0);
		rchk(6'h00, 32'h000, 32'h3FF);
		wr(6'h08, 32'h4);
		rchk(6'h00, 32'h040, 32'h0C0);
		chk({31'h0, tx_on}, 32'h0, 32'h1);
		pulse(1'b0);
	endtask
	task t_rx;
		u_far.send(9'h055, 1'b1, 1'b0, 1'b0);
		rchk(6'h00, 32'h0E0, 32'h3FF);
		chk({31'h0, rx_req}, 32'h1, 32'h1);
		rchk(6'h04, 32'h055, 32'h1FF);
		rchk(6'h00, 32'h0C0, 32'h3FF);
		u_far.send(9'h101, 1'b1, 1'b0, 1'b0);
		u_far.send(9'h102, 1'b1, 1'b0, 1'b0);
		rchk(6'h00, 32'h0E8, 32'h3FF);
		rchk(6'h04, 32'h102, 32'h1FF);
		rchk(6'h00, 32'h0C0, 32'h3FF);
		u_far.idle_frame();
		u_far.send(9'h033, 1'b1, 1'b0, 1'b1);
		rchk(6'h00, 32'h0F4, 32'h3FF);
		u_far.idle_frame();
		rchk(6'h04, 32'h033, 32'h1FF);
		rchk(6'h00, 32'h0C0, 32'h3FF);
		rchk(6'h00, 32'h0C0, 32'h3FF);
		u_far.idle_frame();
		rchk(6'h04, 32'h033, 32'h1FF);
		rchk(6'h00, 32'h0D0, 32'h3FF);
		rchk(6'h04, 32'h033, 32'h1FF);
		rchk(6'h00, 32'h0C0, 32'h3FF);
	endtask
	task t_err(input logic par);
		// Low stop bit for the framing case, bad parity with a good stop bit otherwise
		u_far.send(9'h0AB, par, par, 1'b0);
		repeat (3) begin
			#1;
			chk({30'h0, rx_halt, rx_req}, 32'h2, 32'h3);
			@(posedge mclk_in);
		end
		u_far.send(9'h011, 1'b1, 1'b0, 1'b0);
		rchk(6'h00, par ? 32'h0C1 : 32'h0C2, 32'h3DF);
		rchk(6'h04, 32'h0AB, 32'h1FF);
		rchk(6'h00, 32'h0C0, 32'h3FF);
		chk({31'h0, rx_halt}, 32'h0, 32'h1);
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset_cts();
		t_tx();
		t_rx();
		t_err(1'b0);
		t_err(1'b1);
		report_and_stop();
	end
	// Whole run is about 150 cycles; this leaves a wide margin
	initial begin
		#(20 * 20000);
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
